// File: dv/iapfc_ctrl_sva.sv
// Port assertions of the flash programming block
`timescale 1ns/1ns
module iapfc_ctrl_sva #(
    parameter int ERASE_CYC_0 = 40,
    parameter int WRITE_CYC_0 = 50,
    parameter int ERASE_CYC_1 = 60,
    parameter int WRITE_CYC_1 = 70
) (
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic [3:0]  i_sfr_addr,
    input wire logic        i_sfr_wr,
    input wire logic [7:0]  i_sfr_wdata,
    input wire logic [7:0]  o_sfr_rdata,
    input wire logic        o_flash_strobe,
    input wire logic        o_flash_erase,
    input wire logic [15:0] o_flash_wdata,
    input wire logic        o_flash_rd,
    input wire logic        o_cpu_halt,
    input wire logic        o_chip_reset
);
    logic       sel;
    logic [2:0] mode;
    int         hcnt;
    int         exp_n;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Mode and time select as last written, since ops start from them
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sel  <= 1'b0;
            mode <= 3'h0;
        end else if (i_sfr_wr && i_sfr_addr == 4'h2) begin
            sel <= i_sfr_wdata[1];
        end else if (i_sfr_wr && i_sfr_addr == 4'h0) begin
            mode <= i_sfr_wdata[6:4];
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hcnt <= 0;
        end else begin
            hcnt <= o_cpu_halt ? hcnt + 1 : 0;
        end
    end
    assign exp_n = (mode == 3'h3) ? 1 : (mode == 3'h1) ?
        (sel ? ERASE_CYC_1 : ERASE_CYC_0) : (sel ? WRITE_CYC_1 : WRITE_CYC_0);
    sequence s_key; i_sfr_wr && i_sfr_addr == 4'h1; endsequence
    sequence s_pulse; o_chip_reset ##1 !o_chip_reset; endsequence
    property p_key; s_key and i_sfr_wdata == 8'h55 |=> s_pulse; endproperty
    a_key: assert property (p_key) else $error("no reset pulse");
    property p_nokey; s_key and i_sfr_wdata != 8'h55 |=> !o_chip_reset;
    endproperty
    a_nokey: assert property (p_nokey) else $error("false reset");
    property p_tbz; i_sfr_addr == 4'h2 |=> o_sfr_rdata[7:2] == 6'h00;
    endproperty
    a_tbz: assert property (p_tbz) else $error("ctrl bits set");
    property p_ahz; i_sfr_addr == 4'h4 |=> o_sfr_rdata[7:6] == 2'h0;
    endproperty
    a_ahz: assert property (p_ahz) else $error("addr bits set");
    property p_strb; o_flash_strobe |-> o_cpu_halt; endproperty
    a_strb: assert property (p_strb) else $error("strobe unhalted");
    property p_erz; o_flash_strobe && o_flash_erase |-> !o_flash_wdata;
    endproperty
    a_erz: assert property (p_erz) else $error("erase data");
    property p_rdh; o_flash_rd |-> o_cpu_halt ##1 !o_flash_rd; endproperty
    a_rdh: assert property (p_rdh) else $error("read halt");
    property p_len; $fell(o_cpu_halt) |-> hcnt == exp_n; endproperty
    a_len: assert property (p_len) else $error("op length");
endmodule
bind iapfc_ctrl iapfc_ctrl_sva #(.ERASE_CYC_0(ERASE_CYC_0),
    .WRITE_CYC_0(WRITE_CYC_0), .ERASE_CYC_1(ERASE_CYC_1),
    .WRITE_CYC_1(WRITE_CYC_1)) u_sva (.i_sys_clk, .i_rst, .i_sfr_addr,
    .i_sfr_wr, .i_sfr_wdata, .o_sfr_rdata, .o_flash_strobe, .o_flash_erase,
    .o_flash_wdata, .o_flash_rd, .o_cpu_halt, .o_chip_reset);

// File: dv/tb_iapfc_ctrl.sv
// Self-checking bench of the flash programming block
`timescale 1ns/1ns
module tb_iapfc_ctrl;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic [3:0]  a = 4'h0;
    logic [7:0]  d = 8'h00;
    logic [7:0]  q;
    logic        stb, halt, crst;
    logic [15:0] fd;
    logic [13:0] fa;
    logic [15:0] frd = 16'h0000;
    int          failures = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    iapfc_ctrl #(.ERASE_CYC_0(40), .WRITE_CYC_0(50), .ERASE_CYC_1(60),
        .WRITE_CYC_1(70), .UNLOCK_CYC(60)) dut (.i_sys_clk(clk),
        .i_rst(rst), .i_sfr_addr(a), .i_sfr_wr(wr), .i_sfr_wdata(d),
        .o_sfr_rdata(q), .o_flash_strobe(stb), .o_flash_erase(),
        .o_flash_addr(fa), .o_flash_wdata(fd), .o_flash_rd(),
        .i_flash_rdata(frd), .o_cpu_halt(halt), .o_chip_reset(crst));
    initial forever #50 clk = ~clk;
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    // Idle cycle first so the strobe never toggles twice in one step
    task automatic w(logic [3:0] x, logic [7:0] v);
        @(negedge clk);
        a = x;
        d = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic r(logic [3:0] x, logic [7:0] e);
        a = x;
        @(negedge clk);
        chk($sformatf("reg %h", x), {8'h00, e}, {8'h00, q});
    endtask
    task automatic op(logic [7:0] c, int n, int ns, logic [15:0] v,
                      logic [7:0] e);
        int k = 0;
        int s = 0;
        w(4'h0, c);
        while (halt === 1'b1 && k < 300) begin
            k++;
            if (stb === 1'b1) begin
                chk("flash addr", 16'h0040 + 16'(s), {2'h0, fa});
                s++;
                chk("flash data", v, fd);
            end
            @(negedge clk);
        end
        chk("halt cycles", 16'(n), 16'(k));
        chk("strobes", 16'(ns), 16'(s));
        r(4'h0, e);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        logic [7:0] pat [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) r(4'(i), 8'h00);
        w(4'h2, 8'hfc);
        r(4'h2, 8'h00);
        w(4'h4, 8'hff);
        r(4'h4, 8'h3f);
        for (int i = 7; i < 13; i++) begin
            w(4'(i), 8'ha5);
            r(4'(i), 8'ha5);
        end
        $display("register test done");
        w(4'h1, 8'h12);
        chk("chip reset", 16'h0, {15'h0, crst});
        w(4'h1, 8'h55);
        chk("chip reset", 16'h1, {15'h0, crst});
        r(4'h1, 8'h55);
        $display("key test done");
        w(4'h3, 8'hfe);
        w(4'h5, 8'h11);
        r(4'h3, 8'hfe);
        w(4'h6, 8'h22);
        r(4'h3, 8'hff);
        w(4'h6, 8'h33);
        r(4'h3, 8'hff);
        r(4'h4, 8'h3f);
        w(4'h0, 8'h04);
        chk("halt", 16'h0, {15'h0, halt});
        r(4'h0, 8'h00);
        $display("locked load test done");
        w(4'h0, 8'h68);
        for (int i = 0; i < 6; i++) w(4'(7 + i), pat[i]);
        // Enable bit lands one edge after the last pattern byte
        @(negedge clk);
        r(4'h0, 8'he8);
        $display("unlock test done");
        w(4'h2, 8'h01);
        r(4'h2, 8'h01);
        r(4'h2, 8'h00);
        w(4'h3, 8'h40);
        w(4'h4, 8'h00);
        for (int i = 0; i < 2; i++) begin
            w(4'h5, 8'hcd);
            w(4'h6, 8'hab);
        end
        op(8'h84, 50, 2, 16'habcd, 8'h80);
        $display("write test done");
        w(4'h2, 8'h02);
        w(4'h3, 8'h40);
        w(4'h6, 8'h77);
        op(8'h94, 60, 1, 16'h0000, 8'h90);
        $display("erase test done");
        frd = 16'h1234;
        op(8'h33, 1, 0, 16'h0000, 8'h32);
        r(4'h5, 8'h34);
        r(4'h6, 8'h12);
        $display("read test done");
        report_and_stop();
    end
endmodule

// File: rtl/iapfc_ctrl.sv
// Register file, write buffer and sequencer of the flash programming block
`timescale 1ns/1ns
module iapfc_ctrl #(
    parameter int ERASE_CYC_0 =
        (iapfc_pkg::ERASE_T0_NS + iapfc_pkg::CLK_PERIOD_NS - 1)
        / iapfc_pkg::CLK_PERIOD_NS,
    parameter int WRITE_CYC_0 =
        (iapfc_pkg::WRITE_T0_NS + iapfc_pkg::CLK_PERIOD_NS - 1)
        / iapfc_pkg::CLK_PERIOD_NS,
    parameter int ERASE_CYC_1 =
        (iapfc_pkg::ERASE_T1_NS + iapfc_pkg::CLK_PERIOD_NS - 1)
        / iapfc_pkg::CLK_PERIOD_NS,
    parameter int WRITE_CYC_1 =
        (iapfc_pkg::WRITE_T1_NS + iapfc_pkg::CLK_PERIOD_NS - 1)
        / iapfc_pkg::CLK_PERIOD_NS,
    parameter int UNLOCK_CYC  =
        (iapfc_pkg::UNLOCK_T_NS + iapfc_pkg::CLK_PERIOD_NS - 1)
        / iapfc_pkg::CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Special function register port
    input  wire logic [3:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic [7:0]  i_sfr_wdata,
    output logic      [7:0]  o_sfr_rdata,
    // Flash array port
    output logic             o_flash_strobe,
    output logic             o_flash_erase,
    output logic      [13:0] o_flash_addr,
    output logic      [15:0] o_flash_wdata,
    output logic             o_flash_rd,
    input  wire logic [15:0] i_flash_rdata,
    // System
    output logic             o_cpu_halt,
    output logic             o_chip_reset
);

    localparam int TW = iapfc_pkg::TIMER_W;
    localparam int NW = iapfc_pkg::PAGE_WORDS;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    iapfc_pkg::iapfc_state_t state;
    iapfc_pkg::iapfc_mode_t  mode;
    logic        enabled;
    logic        trigger;
    logic        wr_init;
    logic        rd_en;
    logic        rd_init;
    logic [7:0]  chip_reset_key;
    logic        time_sel;
    logic        clear_buf;
    logic [13:0] flash_address;
    logic [7:0]  word0_low;
    logic [7:0]  word0_high;
    logic [7:0]  word1_low;
    logic [7:0]  word1_high;
    logic [7:0]  word2_low;
    logic [7:0]  word2_high;
    logic [7:0]  word3_low;
    logic [7:0]  word3_high;
    logic [15:0] wbuf [NW];
    logic [NW-1:0] tags;
    logic        op_erase;
    logic [5:0]  commit_idx;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    logic wr_main;
    logic wr_key;
    logic wr_tb;
    logic wr_al;
    logic wr_ah;
    logic wr_w0h;
    logic mode_wr_ok;
    logic start_op;
    logic start_rd;
    logic start_unlock;
    logic pattern_ok;
    logic [2:0] new_mode;

    assign wr_main = i_sfr_wr && i_sfr_addr == iapfc_pkg::IDX_MAIN_CTRL;
    assign wr_key  = i_sfr_wr && i_sfr_addr == iapfc_pkg::IDX_RESET_KEY;
    assign wr_tb   = i_sfr_wr && i_sfr_addr == iapfc_pkg::IDX_TB_CTRL;
    assign wr_al   = i_sfr_wr && i_sfr_addr == iapfc_pkg::IDX_ADDR_LOW;
    assign wr_ah   = i_sfr_wr && i_sfr_addr == iapfc_pkg::IDX_ADDR_HIGH;
    assign wr_w0h  = i_sfr_wr && i_sfr_addr == iapfc_pkg::IDX_WORD0_HI;
    assign new_mode = i_sfr_wdata[iapfc_pkg::MC_MODE_LSB +: 3];

    // Mode written in the same instruction is the one that counts
    assign mode_wr_ok = new_mode == iapfc_pkg::MODE_WRITE
                     || new_mode == iapfc_pkg::MODE_ERASE;
    assign start_op = wr_main && i_sfr_wdata[iapfc_pkg::MC_WR_INIT]
                   && enabled && mode_wr_ok
                   && state == iapfc_pkg::ST_IDLE;
    assign start_rd = wr_main && i_sfr_wdata[iapfc_pkg::MC_RD_INIT]
                   && i_sfr_wdata[iapfc_pkg::MC_RD_EN]
                   && new_mode == iapfc_pkg::MODE_READ
                   && state == iapfc_pkg::ST_IDLE;
    assign start_unlock = wr_main && i_sfr_wdata[iapfc_pkg::MC_TRIGGER]
                       && new_mode == iapfc_pkg::MODE_UNLOCK && !trigger;

    assign pattern_ok = word1_low  == iapfc_pkg::PAT_W1_LOW
                     && word2_low  == iapfc_pkg::PAT_W2_LOW
                     && word3_low  == iapfc_pkg::PAT_W3_LOW
                     && word1_high == iapfc_pkg::PAT_W1_HIGH
                     && word2_high == iapfc_pkg::PAT_W2_HIGH
                     && word3_high == iapfc_pkg::PAT_W3_HIGH;

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    iapfc_tmr_if #(.W(TW)) op_tif ();
    iapfc_tmr_if #(.W(TW)) ul_tif ();

    iapfc_timer #(.W(TW)) u_op_timer (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .tif       (op_tif)
    );

    iapfc_timer #(.W(TW)) u_unlock_timer (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .tif       (ul_tif)
    );

    always_comb begin
        op_tif.start = start_op;
        if (new_mode == iapfc_pkg::MODE_ERASE) begin
            op_tif.cycles = time_sel ? TW'(ERASE_CYC_1)
                                     : TW'(ERASE_CYC_0);
        end else begin
            op_tif.cycles = time_sel ? TW'(WRITE_CYC_1)
                                     : TW'(WRITE_CYC_0);
        end
    end

    assign ul_tif.start  = start_unlock;
    assign ul_tif.cycles = TW'(UNLOCK_CYC);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= iapfc_pkg::ST_IDLE;
        end else begin
            unique case (state)
                iapfc_pkg::ST_IDLE: begin
                    if (start_op) begin
                        state <= iapfc_pkg::ST_BUSY;
                    end else if (start_rd) begin
                        state <= iapfc_pkg::ST_READ;
                    end
                end
                iapfc_pkg::ST_BUSY: begin
                    if (op_tif.done) begin
                        state <= iapfc_pkg::ST_IDLE;
                    end
                end
                iapfc_pkg::ST_READ: begin
                    state <= iapfc_pkg::ST_IDLE;
                end
                default: begin
                    state <= iapfc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign o_cpu_halt = state != iapfc_pkg::ST_IDLE;

    // ------------------------------------------------------------------
    // Main control register
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mode    <= iapfc_pkg::MODE_WRITE;
            rd_en   <= 1'b0;
        end else if (wr_main) begin
            mode    <= iapfc_pkg::iapfc_mode_t'(new_mode);
            rd_en   <= i_sfr_wdata[iapfc_pkg::MC_RD_EN];
        end
    end

    // Software can only drop it; hardware set wins over that clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            enabled <= 1'b0;
        end else if (trigger && ul_tif.busy && pattern_ok) begin
            enabled <= 1'b1;
        end else if (wr_main && !i_sfr_wdata[iapfc_pkg::MC_ENABLED]) begin
            enabled <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            trigger <= 1'b0;
        end else if (start_unlock) begin
            trigger <= 1'b1;
        end else if (ul_tif.done) begin
            trigger <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_init  <= 1'b0;
            op_erase <= 1'b0;
        end else if (start_op) begin
            wr_init  <= 1'b1;
            op_erase <= new_mode == iapfc_pkg::MODE_ERASE;
        end else if (state == iapfc_pkg::ST_BUSY && op_tif.done) begin
            wr_init  <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_init <= 1'b0;
        end else if (start_rd) begin
            rd_init <= 1'b1;
        end else if (state == iapfc_pkg::ST_READ) begin
            rd_init <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Chip reset key and timing/buffer control
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            chip_reset_key <= iapfc_pkg::REG_RESET;
            o_chip_reset   <= 1'b0;
        end else begin
            if (wr_key) begin
                chip_reset_key <= i_sfr_wdata;
            end
            o_chip_reset <= wr_key && i_sfr_wdata == iapfc_pkg::CHIP_KEY;
        end
    end

    // A fresh set in the clearing cycle keeps the bit up
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            time_sel  <= 1'b0;
            clear_buf <= 1'b0;
        end else if (wr_tb) begin
            time_sel  <= i_sfr_wdata[iapfc_pkg::TB_TIME_SEL];
            clear_buf <= i_sfr_wdata[iapfc_pkg::TB_CLEAR];
        end else if (clear_buf) begin
            clear_buf <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            flash_address <= iapfc_pkg::ADDR_RESET;
        end else if (wr_al) begin
            flash_address[7:0] <= i_sfr_wdata;
        end else if (wr_ah) begin
            flash_address[13:8] <= i_sfr_wdata[5:0];
        end else if (wr_w0h && flash_address[4:0] != iapfc_pkg::PAGE_LAST) begin
            flash_address <= flash_address + 14'h0001;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            word0_low  <= iapfc_pkg::REG_RESET;
            word0_high <= iapfc_pkg::REG_RESET;
        end else if (state == iapfc_pkg::ST_READ) begin
            word0_low  <= i_flash_rdata[7:0];
            word0_high <= i_flash_rdata[15:8];
        end else if (i_sfr_wr) begin
            if (i_sfr_addr == iapfc_pkg::IDX_WORD0_LOW) begin
                word0_low <= i_sfr_wdata;
            end
            if (i_sfr_addr == iapfc_pkg::IDX_WORD0_HI) begin
                word0_high <= i_sfr_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            word1_low  <= iapfc_pkg::REG_RESET;
            word1_high <= iapfc_pkg::REG_RESET;
            word2_low  <= iapfc_pkg::REG_RESET;
            word2_high <= iapfc_pkg::REG_RESET;
            word3_low  <= iapfc_pkg::REG_RESET;
            word3_high <= iapfc_pkg::REG_RESET;
        end else if (i_sfr_wr) begin
            unique case (i_sfr_addr)
                iapfc_pkg::IDX_WORD1_LOW: word1_low  <= i_sfr_wdata;
                iapfc_pkg::IDX_WORD1_HI:  word1_high <= i_sfr_wdata;
                iapfc_pkg::IDX_WORD2_LOW: word2_low  <= i_sfr_wdata;
                iapfc_pkg::IDX_WORD2_HI:  word2_high <= i_sfr_wdata;
                iapfc_pkg::IDX_WORD3_LOW: word3_low  <= i_sfr_wdata;
                iapfc_pkg::IDX_WORD3_HI:  word3_high <= i_sfr_wdata;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Write buffer and tags
    // ------------------------------------------------------------------
    // Buffer fills only once unlocked, so a stray store never programs
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tags <= '0;
            for (int i = 0; i < NW; i++) begin
                wbuf[i] <= iapfc_pkg::WORD_RESET;
            end
        end else if (clear_buf
                     || (state == iapfc_pkg::ST_BUSY && op_tif.done)) begin
            tags <= '0;
            for (int i = 0; i < NW; i++) begin
                wbuf[i] <= iapfc_pkg::WORD_RESET;
            end
        end else if (wr_w0h && enabled) begin
            wbuf[flash_address[4:0]] <= {i_sfr_wdata, word0_low};
            tags[flash_address[4:0]] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Flash array commit
    // ------------------------------------------------------------------
    // Tagged words go out early in the timed window; the timer alone
    // decides when the operation is reported complete
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            commit_idx <= 6'h00;
        end else if (start_op) begin
            commit_idx <= 6'h00;
        end else if (state == iapfc_pkg::ST_BUSY && !commit_idx[5]) begin
            commit_idx <= commit_idx + 6'h01;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flash_strobe <= 1'b0;
            o_flash_erase  <= 1'b0;
            o_flash_addr   <= iapfc_pkg::ADDR_RESET;
            o_flash_wdata  <= iapfc_pkg::WORD_RESET;
            o_flash_rd     <= 1'b0;
        end else begin
            o_flash_strobe <= state == iapfc_pkg::ST_BUSY && !commit_idx[5]
                           && tags[commit_idx[4:0]];
            o_flash_erase  <= op_erase;
            o_flash_rd     <= start_rd;
            if (start_rd) begin
                o_flash_addr <= flash_address;
            end else if (state == iapfc_pkg::ST_BUSY) begin
                o_flash_addr  <= {flash_address[13:5], commit_idx[4:0]};
                o_flash_wdata <= op_erase ? iapfc_pkg::WORD_RESET
                                          : wbuf[commit_idx[4:0]];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sfr_rdata <= iapfc_pkg::REG_RESET;
        end else begin
            unique case (i_sfr_addr)
                iapfc_pkg::IDX_MAIN_CTRL:
                    o_sfr_rdata <= {enabled, mode, trigger, wr_init,
                                    rd_en, rd_init};
                iapfc_pkg::IDX_RESET_KEY: o_sfr_rdata <= chip_reset_key;
                iapfc_pkg::IDX_TB_CTRL:
                    o_sfr_rdata <= {6'h00, time_sel, clear_buf};
                iapfc_pkg::IDX_ADDR_LOW:  o_sfr_rdata <= flash_address[7:0];
                iapfc_pkg::IDX_ADDR_HIGH:
                    o_sfr_rdata <= {2'h0, flash_address[13:8]};
                iapfc_pkg::IDX_WORD0_LOW: o_sfr_rdata <= word0_low;
                iapfc_pkg::IDX_WORD0_HI:  o_sfr_rdata <= word0_high;
                iapfc_pkg::IDX_WORD1_LOW: o_sfr_rdata <= word1_low;
                iapfc_pkg::IDX_WORD1_HI:  o_sfr_rdata <= word1_high;
                iapfc_pkg::IDX_WORD2_LOW: o_sfr_rdata <= word2_low;
                iapfc_pkg::IDX_WORD2_HI:  o_sfr_rdata <= word2_high;
                iapfc_pkg::IDX_WORD3_LOW: o_sfr_rdata <= word3_low;
                iapfc_pkg::IDX_WORD3_HI:  o_sfr_rdata <= word3_high;
                default:                  o_sfr_rdata <= iapfc_pkg::REG_RESET;
            endcase
        end
    end

endmodule

// File: rtl/iapfc_pkg.sv
// Constants and types of the in-application flash programming controller
//
// Contract
// - Writing 55h to key register resets chip
// - Time select 0: erase 3.2ms, write 2.2ms
// - Time select 1: erase 3.7ms, write 3.0ms
// - Buffer clear bit self-clears after clearing buffer
// - Unimplemented control and address bits read zero
// - Fourteen-bit address split over low/high registers
// - Word0 low write only stores the byte
// - Word0 high write loads buffer, bumps address; the code loads the buffer only while enabled is set
// - Tag writes mark erase words, bump address
// - Address stops at last word of page
// - Correct unlock pattern sets enabled bit
// - Erased words read back as zero
// - Erase and write need prior unlock
// - Words one to three are plain registers
// - Mode codes: write, erase, read, unlock
// - Write-initiate bit clears when operation ends
// - CPU halted while flash operation runs
package iapfc_pkg;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_MAIN_CTRL = 4'h0;
    localparam logic [3:0] IDX_RESET_KEY = 4'h1;
    localparam logic [3:0] IDX_TB_CTRL   = 4'h2;
    localparam logic [3:0] IDX_ADDR_LOW  = 4'h3;
    localparam logic [3:0] IDX_ADDR_HIGH = 4'h4;
    localparam logic [3:0] IDX_WORD0_LOW = 4'h5;
    localparam logic [3:0] IDX_WORD0_HI  = 4'h6;
    localparam logic [3:0] IDX_WORD1_LOW = 4'h7;
    localparam logic [3:0] IDX_WORD1_HI  = 4'h8;
    localparam logic [3:0] IDX_WORD2_LOW = 4'h9;
    localparam logic [3:0] IDX_WORD2_HI  = 4'ha;
    localparam logic [3:0] IDX_WORD3_LOW = 4'hb;
    localparam logic [3:0] IDX_WORD3_HI  = 4'hc;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MC_ENABLED  = 7;
    localparam int MC_MODE_LSB = 4;
    localparam int MC_TRIGGER  = 3;
    localparam int MC_WR_INIT  = 2;
    localparam int MC_RD_EN    = 1;
    localparam int MC_RD_INIT  = 0;
    localparam int TB_TIME_SEL = 1;
    localparam int TB_CLEAR    = 0;

    // ------------------------------------------------------------------
    // Reset values and patterns
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [13:0] ADDR_RESET  = 14'h0000;
    localparam logic [15:0] WORD_RESET  = 16'h0000;
    localparam logic [7:0]  CHIP_KEY    = 8'h55;
    localparam logic [4:0]  PAGE_LAST   = 5'h1f;
    localparam logic [7:0]  PAT_W1_LOW  = 8'h00;
    localparam logic [7:0]  PAT_W2_LOW  = 8'h0d;
    localparam logic [7:0]  PAT_W3_LOW  = 8'hc3;
    localparam logic [7:0]  PAT_W1_HIGH = 8'h04;
    localparam logic [7:0]  PAT_W2_HIGH = 8'h09;
    localparam logic [7:0]  PAT_W3_HIGH = 8'h40;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int ERASE_T0_NS    = 3200000;
    localparam int WRITE_T0_NS    = 2200000;
    localparam int ERASE_T1_NS    = 3700000;
    localparam int WRITE_T1_NS    = 3000000;
    localparam int UNLOCK_T_NS    = 1000000;
    localparam int TIMER_W        = 16;
    localparam int PAGE_WORDS     = 32;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_WRITE  = 3'h0,
        MODE_ERASE  = 3'h1,
        MODE_READ   = 3'h3,
        MODE_UNLOCK = 3'h6
    } iapfc_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_BUSY = 3'h2,
        ST_READ = 3'h4
    } iapfc_state_t;

endpackage

// File: rtl/iapfc_timer.sv
// One-shot down-counter timing flash operations and the unlock window
`timescale 1ns/1ns
module iapfc_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // Control
    iapfc_tmr_if.tmr  tif
);

    logic [W-1:0] count;

    // Busy exactly for the loaded number of cycles
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
        end else if (tif.start && !tif.busy) begin
            count <= tif.cycles;
        end else if (tif.busy) begin
            count <= count - W'(1);
        end
    end

    assign tif.busy = (count != '0);
    assign tif.done = (count == W'(1));

endmodule

// File: rtl/iapfc_tmr_if.sv
// Start/done handshake between controller and its down-counters
`timescale 1ns/1ns
interface iapfc_tmr_if #(
    parameter int W = 16
);
    logic         start;
    logic [W-1:0] cycles;
    logic         busy;
    logic         done;

    modport ctrl (output start, output cycles, input busy, input done);
    modport tmr  (input start, input cycles, output busy, output done);
endinterface
